// ===== logic/i2c_mode_pkg.sv
// Shared constants and types for the two-wire mode control block
package i2c_mode_pkg;
  // Timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int BIT_PERIOD_NS = 10000;
  localparam int QUARTER_CYC = BIT_PERIOD_NS / (4 * CLK_PERIOD_NS);
  localparam int FIFO_DEPTH = 16;
  // Register byte offsets
  localparam logic [7:0] OFF_MODE = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_TXDATA = 8'h08;
  localparam logic [7:0] OFF_RXDATA = 8'h0C;
  localparam logic [7:0] OFF_TARGET = 8'h10;
  localparam logic [7:0] OFF_COUNT = 8'h14;
  // Mode register fields
  localparam int BC_LSB = 0;
  localparam int FDF_BIT = 3;
  localparam int STB_BIT = 4;
  localparam int IRS_BIT = 5;
  localparam int DLB_BIT = 6;
  localparam int RM_BIT = 7;
  localparam int XA_BIT = 8;
  localparam int TRX_BIT = 9;
  localparam int MST_BIT = 10;
  localparam int STP_BIT = 11;
  localparam int STT_BIT = 13;
  localparam logic [15:0] MODE_RESET = 16'h0000;
  localparam logic [15:0] MODE_WMASK = 16'h2FFF;
  // Status register fields
  localparam int ST_BUSY = 0;
  localparam int ST_NACK = 1;
  localparam int ST_TXRDY = 2;
  localparam int ST_RXRDY = 3;
  localparam int ST_SLV = 4;
  localparam int ST_ARDY = 5;
  // Bus constants
  localparam logic [7:0] START_BYTE = 8'h01;
  localparam logic [4:0] TEN_BIT_HDR = 5'h1E;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {SYM_START, SYM_STOP, SYM_BIT} sym_t;
  typedef enum logic [3:0] {
    M_IDLE, M_START, M_SBYTE, M_SACK, M_RSTART, M_ADDR, M_AACK,
    M_LOAD, M_DATA, M_DACK, M_HOLD, M_STOP
  } mstate_t;
endpackage : i2c_mode_pkg

// ===== logic/sync_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sync_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = i2c_mode_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  import i2c_mode_pkg::*;
  localparam int PW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
    $error("sync_fifo: DEPTH must be a power of two of at least 2");
  end
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
  } fifo_t;
  fifo_t s_r, s_nxt;
  logic push, pop;

  assign in_ready = s_r.cnt != (PW+1)'(DEPTH);
  assign out_valid = s_r.cnt != '0;
  assign out_data = s_r.mem[s_r.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.mem[s_r.wp] = in_data;
      s_nxt.wp = s_r.wp + PW'(1);
    end
    if (pop) begin
      s_nxt.rp = s_r.rp + PW'(1);
    end
    s_nxt.cnt = s_r.cnt + (PW+1)'(push) - (PW+1)'(pop);
    if (!aresetn) begin
      s_nxt = '0;
    end
  end

  always_ff @(posedge aclk) begin
    s_r <= s_nxt;
  end
endmodule : sync_fifo
`default_nettype wire

// ===== logic/bus_symbol_engine.sv
// Produces one bus symbol (START, STOP or one data bit) in four quarter phases
`timescale 1ns/1ps
`default_nettype none
module bus_symbol_engine #(
  parameter int QUARTER = i2c_mode_pkg::QUARTER_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic abort,
  // Symbol request
  input wire logic sym_valid,
  input wire i2c_mode_pkg::sym_t sym_kind,
  input wire logic sym_bit,
  output logic sym_ready,
  output logic sym_done,
  output logic sym_sample,
  // Bus lines
  input wire logic sda_in,
  output logic scl_drive_n,
  output logic sda_drive_n
);
  import i2c_mode_pkg::*;
  localparam int CW = $clog2(QUARTER + 1);
  if (QUARTER < 1) begin : g_bad_quarter
    $error("bus_symbol_engine: QUARTER must be at least 1");
  end
  typedef struct packed {
    logic busy;
    logic [1:0] phase;
    logic [CW-1:0] cnt;
    sym_t kind;
    logic bit_v;
    logic scl_low;
    logic sda_low;
    logic done;
    logic sample;
  } eng_t;
  eng_t s_r, s_nxt;

  // Returns {scl_low, sda_low} for a phase
  function automatic logic [1:0] lines(sym_t k, logic [1:0] ph, logic b, logic scl_now);
    case (k)
      SYM_START: lines = (ph == 2'h3) ? 2'h3 : (ph == 2'h2) ? 2'h1 :
                         (ph == 2'h1) ? 2'h0 : {scl_now, 1'b0};
      SYM_STOP: lines = (ph == 2'h0) ? 2'h3 : (ph == 2'h3) ? 2'h0 : 2'h1;
      default: lines = {ph == 2'h0 || ph == 2'h3, ~b};
    endcase
  endfunction

  assign sym_ready = !s_r.busy;
  assign sym_done = s_r.done;
  assign sym_sample = s_r.sample;
  assign scl_drive_n = !s_r.scl_low;
  assign sda_drive_n = !s_r.sda_low;

  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    if (!s_r.busy) begin
      if (sym_valid) begin
        s_nxt.busy = 1'b1;
        s_nxt.phase = 2'h0;
        s_nxt.cnt = '0;
        s_nxt.kind = sym_kind;
        s_nxt.bit_v = sym_bit;
      end
    end else if (s_r.cnt == CW'(QUARTER - 1)) begin
      s_nxt.cnt = '0;
      if (s_r.phase == 2'h2) begin
        s_nxt.sample = sda_in;
      end
      if (s_r.phase == 2'h3) begin
        s_nxt.busy = 1'b0;
        s_nxt.done = 1'b1;
      end
      s_nxt.phase = s_r.phase + 2'h1;
    end else begin
      s_nxt.cnt = s_r.cnt + CW'(1);
    end
    // Lines keep their last level between symbols
    if (s_nxt.busy) begin
      {s_nxt.scl_low, s_nxt.sda_low} = lines(s_nxt.kind, s_nxt.phase, s_nxt.bit_v, s_r.scl_low);
    end
    if (!aresetn || abort) begin
      s_nxt = '0;
    end
  end

  always_ff @(posedge aclk) begin
    s_r <= s_nxt;
  end
endmodule : bus_symbol_engine
`default_nettype wire

// ===== logic/i2c_mode_ctrl.sv
// Two-wire bus controller: mode register low fields, master sequencer, AXI4-Lite slave
// Functional notes
// RQ1: While the run bit is 0 the module is held disabled and every status flag returns to 0.
// RQ2: Setting the run bit enables the module and leaves both bus lines released.
// RQ3: With start byte mode, a master start sends START, byte 01h, a dummy ack clock, repeated START.
// RQ4: As a slave the block ignores a START byte, whatever start byte mode holds.
// RQ5: With free format off, transfers carry the 7-bit or 10-bit address chosen by expanded mode.
// RQ6: With free format on, no address is sent and data follows the START directly.
// RQ7: Software must not enable free format while loopback is set.
// RQ8: The bit count field sets the data byte width: 0 means 8 bits, 1 to 7 mean that many.
// RQ9: Address bytes are always 8 bits whatever the bit count field holds.
// RQ10: The programmed data width must match the width used by the far device.
// RQ11: Fewer than 8 received bits are right-justified in the receive data register.
// RQ12: Software writes short transmit data right-justified.
// RQ13: Bit 12 of the mode register ignores writes and reads as 0.
// RQ14: Expanded mode 0 sends the low seven target bits, 1 sends the low ten bits.
// RQ15: A non-repeat master start sends START, address and byte count data bytes.
// RQ16: While the run bit is 0 both lines stay released and bus activity is ignored.
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module i2c_mode_ctrl #(
  parameter int QUARTER = i2c_mode_pkg::QUARTER_CYC,
  parameter int TX_DEPTH = i2c_mode_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Bus lines
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n
);
  import i2c_mode_pkg::*;
  typedef struct packed {
    logic [15:0] mode;
    logic [9:0] target;
    logic [15:0] count;
    logic [15:0] cntdn;
    logic [7:0] rxdata;
    logic nack;
    logic rxrdy;
    logic slv;
    logic ardy;
    mstate_t st;
    logic req;
    sym_t kind;
    logic bitv;
    logic [7:0] shift;
    logic [3:0] bits;
    logic addr2;
    logic awv;
    logic wv;
    logic [7:0] awa;
    logic [31:0] wd;
    logic [3:0] ws;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic pscl;
    logic psda;
    logic sact;
    logic sfirst;
    logic [3:0] sbits;
    logic [7:0] sbyte;
  } ctl_t;
  ctl_t s_r, s_nxt;

  logic module_run_enable, stb, fdf, xa, rm, trx, mst, stp, start_request;
  logic [2:0] bc;
  logic sym_ready, sym_done, sym_sample;
  logic tx_ready, tx_valid, push, pop, wr_fire, last_byte;
  logic [7:0] tx_data, rx_val;
  logic [5:0] status;
  logic sb_done;
  logic [7:0] sb_val;

  function automatic logic [3:0] width_of(logic [2:0] code);
    width_of = (code == 3'h0) ? 4'h8 : {1'b0, code};
  endfunction

  assign module_run_enable = s_r.mode[IRS_BIT];
  assign stb = s_r.mode[STB_BIT];
  assign fdf = s_r.mode[FDF_BIT];
  assign xa = s_r.mode[XA_BIT];
  assign rm = s_r.mode[RM_BIT];
  assign trx = s_r.mode[TRX_BIT];
  assign mst = s_r.mode[MST_BIT];
  assign stp = s_r.mode[STP_BIT];
  assign start_request = s_r.mode[STT_BIT];
  assign bc = s_r.mode[BC_LSB +: 3];
  assign last_byte = !rm && s_r.cntdn == 16'h0000;
  assign rx_val = {s_r.shift[6:0], sym_sample};
  assign sb_val = {s_r.sbyte[6:0], sda_in};
  assign sb_done = s_r.sact && !s_r.pscl && scl_in && s_r.sbits == 4'h7;
  assign status = {s_r.ardy, s_r.slv, s_r.rxrdy, tx_ready && module_run_enable, s_r.nack,
                   s_r.st != M_IDLE};

  // Handshakes
  assign awready = !s_r.awv;
  assign wready = !s_r.wv;
  assign bvalid = s_r.bvalid;
  assign bresp = s_r.bresp;
  assign arready = !s_r.rvalid;
  assign rvalid = s_r.rvalid;
  assign rdata = s_r.rdata;
  assign rresp = s_r.rresp;
  assign wr_fire = s_r.awv && s_r.wv && !s_r.bvalid && (s_r.awa != OFF_TXDATA || tx_ready);
  assign push = wr_fire && s_r.awa == OFF_TXDATA && s_r.ws[0];
  assign pop = s_r.st == M_LOAD && trx && tx_valid && !last_byte && !(rm && stp);
  // Open-drain: only ever pulls low
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;

  sync_fifo #(.WIDTH(8), .DEPTH(TX_DEPTH)) u_tx_fifo (
    .aclk(aclk),
    .aresetn(aresetn && module_run_enable),
    .in_valid(push),
    .in_data(s_r.wd[7:0]),
    .in_ready(tx_ready),
    .out_valid(tx_valid),
    .out_data(tx_data),
    .out_ready(pop)
  );

  bus_symbol_engine #(.QUARTER(QUARTER)) u_engine (
    .aclk(aclk),
    .aresetn(aresetn),
    .abort(!module_run_enable),
    .sym_valid(s_r.req),
    .sym_kind(s_r.kind),
    .sym_bit(s_r.bitv),
    .sym_ready(sym_ready),
    .sym_done(sym_done),
    .sym_sample(sym_sample),
    .sda_in(sda_in),
    .scl_drive_n(scl_oe_n),
    .sda_drive_n(sda_oe_n)
  );

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [15:0] wm;
    wm = MODE_WMASK & {{8{s_r.ws[1]}}, {8{s_r.ws[0]}}};
    s_nxt = s_r;
    if (s_r.req && sym_ready) begin
      s_nxt.req = 1'b0;
    end
    // Register writes
    if (awvalid && awready) begin
      s_nxt.awv = 1'b1;
      s_nxt.awa = awaddr;
    end
    if (wvalid && wready) begin
      s_nxt.wv = 1'b1;
      s_nxt.wd = wdata;
      s_nxt.ws = wstrb;
    end
    if (s_r.bvalid && bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (wr_fire) begin
      s_nxt.awv = 1'b0;
      s_nxt.wv = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = RESP_OKAY;
      case (s_r.awa)
        OFF_MODE: begin
          s_nxt.mode = (s_r.mode & ~wm) | (s_r.wd[15:0] & wm); // RQ13
          if (!s_nxt.mode[IRS_BIT]) begin
            s_nxt.mode[STP_BIT] = 1'b0;
            s_nxt.mode[STT_BIT] = 1'b0;
          end
        end
        OFF_STATUS: begin
          if (s_r.ws[0]) begin
            s_nxt.nack = s_r.nack && !s_r.wd[ST_NACK];
            s_nxt.slv = s_r.slv && !s_r.wd[ST_SLV];
            s_nxt.ardy = s_r.ardy && !s_r.wd[ST_ARDY];
          end
        end
        OFF_TXDATA: ;
        OFF_RXDATA: ;
        OFF_TARGET: begin
          if (s_r.ws[0]) s_nxt.target[7:0] = s_r.wd[7:0];
          if (s_r.ws[1]) s_nxt.target[9:8] = s_r.wd[9:8];
        end
        OFF_COUNT: begin
          if (s_r.ws[0]) s_nxt.count[7:0] = s_r.wd[7:0];
          if (s_r.ws[1]) s_nxt.count[15:8] = s_r.wd[15:8];
        end
        default: s_nxt.bresp = RESP_SLVERR;
      endcase
    end
    // Register reads
    if (s_r.rvalid && rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = RESP_OKAY;
      s_nxt.rdata = 32'h0000_0000;
      case (araddr)
        OFF_MODE: s_nxt.rdata = {16'h0000, s_r.mode};
        OFF_STATUS: s_nxt.rdata = {26'h0, status};
        OFF_TXDATA: s_nxt.rdata = 32'h0000_0000;
        OFF_RXDATA: begin
          s_nxt.rdata = {24'h0, s_r.rxdata};
          s_nxt.rxrdy = 1'b0;
        end
        OFF_TARGET: s_nxt.rdata = {22'h0, s_r.target};
        OFF_COUNT: s_nxt.rdata = {16'h0000, s_r.count};
        default: s_nxt.rresp = RESP_SLVERR;
      endcase
    end
    // Master sequencer
    case (s_r.st)
      M_IDLE: begin
        if (module_run_enable && mst && start_request) begin
          s_nxt.mode[STT_BIT] = 1'b0;
          s_nxt.cntdn = s_r.count; // RQ15
          s_nxt.st = M_START;
          s_nxt.req = 1'b1;
          s_nxt.kind = SYM_START;
        end
      end
      M_START, M_RSTART: begin
        if (sym_done) begin
          s_nxt.req = 1'b1;
          s_nxt.kind = SYM_BIT;
          s_nxt.bits = 4'h8; // RQ9
          if (s_r.st == M_START && stb) begin
            s_nxt.st = M_SBYTE; // RQ3
            s_nxt.shift = START_BYTE;
            s_nxt.bitv = START_BYTE[7];
          end else if (fdf) begin
            s_nxt.st = M_LOAD; // RQ6
            s_nxt.req = 1'b0;
          end else begin
            s_nxt.st = M_ADDR; // RQ5
            s_nxt.addr2 = xa;
            // RQ14
            s_nxt.shift = xa ? {TEN_BIT_HDR, s_r.target[9:8], ~trx} : {s_r.target[6:0], ~trx};
            s_nxt.bitv = s_nxt.shift[7];
          end
        end
      end
      M_SBYTE, M_ADDR: begin
        if (sym_done) begin
          s_nxt.req = 1'b1;
          s_nxt.shift = s_r.shift << 1;
          s_nxt.bits = s_r.bits - 4'h1;
          s_nxt.bitv = s_r.shift[6];
          if (s_r.bits == 4'h1) begin
            s_nxt.st = (s_r.st == M_SBYTE) ? M_SACK : M_AACK;
            s_nxt.bitv = 1'b1;
          end
        end
      end
      M_SACK: begin
        if (sym_done) begin
          s_nxt.st = M_RSTART; // RQ3
          s_nxt.req = 1'b1;
          s_nxt.kind = SYM_START;
        end
      end
      M_AACK: begin
        if (sym_done) begin
          if (sym_sample) begin
            s_nxt.nack = 1'b1;
            s_nxt.st = M_STOP;
            s_nxt.req = 1'b1;
            s_nxt.kind = SYM_STOP;
          end else if (s_r.addr2) begin
            s_nxt.addr2 = 1'b0;
            s_nxt.st = M_ADDR;
            s_nxt.shift = s_r.target[7:0];
            s_nxt.bits = 4'h8; // RQ9
            s_nxt.req = 1'b1;
            s_nxt.bitv = s_r.target[7];
          end else begin
            s_nxt.st = M_LOAD;
          end
        end
      end
      M_LOAD: begin
        if (last_byte || (rm && stp)) begin
          s_nxt.ardy = 1'b1;
          s_nxt.st = stp ? M_STOP : M_HOLD; // RQ15
          s_nxt.req = stp;
          s_nxt.kind = SYM_STOP;
        end else if (!trx || tx_valid) begin
          s_nxt.bits = width_of(bc); // RQ8
          s_nxt.shift = trx ? tx_data << (4'h8 - width_of(bc)) : 8'h00;
          s_nxt.bitv = trx ? s_nxt.shift[7] : 1'b1;
          s_nxt.cntdn = rm ? s_r.cntdn : s_r.cntdn - 16'h0001;
          s_nxt.st = M_DATA;
          s_nxt.req = 1'b1;
          s_nxt.kind = SYM_BIT;
        end
      end
      M_DATA: begin
        if (sym_done) begin
          s_nxt.req = 1'b1;
          s_nxt.shift = trx ? s_r.shift << 1 : rx_val;
          s_nxt.bits = s_r.bits - 4'h1;
          s_nxt.bitv = trx ? s_r.shift[6] : 1'b1;
          if (s_r.bits == 4'h1) begin
            s_nxt.st = M_DACK;
            s_nxt.bitv = trx || last_byte;
            if (!trx) begin
              s_nxt.rxdata = rx_val; // RQ11
              s_nxt.rxrdy = 1'b1;
            end
          end
        end
      end
      M_DACK: begin
        if (sym_done) begin
          if (trx && sym_sample) begin
            s_nxt.nack = 1'b1;
            s_nxt.st = M_STOP;
            s_nxt.req = 1'b1;
            s_nxt.kind = SYM_STOP;
          end else begin
            s_nxt.st = M_LOAD;
          end
        end
      end
      M_HOLD: begin
        if (start_request) begin
          s_nxt.mode[STT_BIT] = 1'b0;
          s_nxt.cntdn = s_r.count;
          s_nxt.st = M_START;
          s_nxt.req = 1'b1;
          s_nxt.kind = SYM_START;
        end else if (stp) begin
          s_nxt.st = M_STOP;
          s_nxt.req = 1'b1;
          s_nxt.kind = SYM_STOP;
        end
      end
      M_STOP: begin
        if (sym_done) begin
          s_nxt.mode[STP_BIT] = 1'b0;
          s_nxt.mode[MST_BIT] = 1'b0;
          s_nxt.st = M_IDLE;
        end
      end
      default: s_nxt.st = M_IDLE;
    endcase
    // Slave listener: watches for START and the first byte
    s_nxt.pscl = scl_in;
    s_nxt.psda = sda_in;
    if (module_run_enable && s_r.st == M_IDLE && !mst) begin
      if (s_r.pscl && scl_in && s_r.psda && !sda_in) begin
        s_nxt.sact = 1'b1;
        s_nxt.sfirst = 1'b1;
        s_nxt.sbits = 4'h0;
      end else if (s_r.pscl && scl_in && !s_r.psda && sda_in) begin
        s_nxt.sact = 1'b0;
      end else if (s_r.sact && !s_r.pscl && scl_in) begin
        s_nxt.sbyte = sb_val;
        s_nxt.sbits = (s_r.sbits == 4'h8) ? 4'h0 : s_r.sbits + 4'h1;
        if (sb_done && s_r.sfirst && sb_val != START_BYTE) begin // RQ4
          s_nxt.slv = 1'b1;
          s_nxt.sfirst = 1'b0;
        end
      end
    end else begin
      s_nxt.sact = 1'b0; // RQ16
    end
    // Disabled module: idle sequencer and default status
    if (!module_run_enable) begin
      s_nxt.st = M_IDLE; // RQ1
      s_nxt.req = 1'b0; // RQ2
      s_nxt.nack = 1'b0;
      s_nxt.rxrdy = 1'b0;
      s_nxt.slv = 1'b0;
      s_nxt.ardy = 1'b0;
    end
    if (!aresetn) begin
      s_nxt = '0;
      s_nxt.mode = MODE_RESET;
    end
  end

  always_ff @(posedge aclk) begin
    s_r <= s_nxt;
  end

  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_off_clears; !module_run_enable |=> !(s_r.nack || s_r.rxrdy || s_r.slv || s_r.ardy); endproperty
  a_off_clears: assert property (p_off_clears) else $error("status not cleared"); // RQ1
  property p_off_release; !module_run_enable |=> scl_oe_n && sda_oe_n && s_r.st == M_IDLE; endproperty
  a_off_release: assert property (p_off_release) else $error("lines held"); // RQ16
  property p_start_byte; s_r.st == M_START && sym_done && stb |=> s_r.st == M_SBYTE && s_r.shift == START_BYTE; endproperty
  a_start_byte: assert property (p_start_byte) else $error("no start byte"); // RQ3
  property p_slave_ignore; sb_done && sb_val == START_BYTE && !s_r.slv && module_run_enable |=> !s_r.slv; endproperty
  a_slave_ignore: assert property (p_slave_ignore) else $error("start byte taken"); // RQ4
  property p_addr_phase; s_r.st == M_START && sym_done && !stb && !fdf |=> s_r.st == M_ADDR; endproperty
  a_addr_phase: assert property (p_addr_phase) else $error("address skipped"); // RQ5
  property p_free;
    s_r.st == M_START && sym_done && fdf && !stb |=> s_r.st == M_LOAD && !s_r.req;
  endproperty
  a_free: assert property (p_free) else $error("address in free format"); // RQ6
  property p_data_width; s_r.st == M_DATA && $past(s_r.st) == M_LOAD |-> s_r.bits == width_of($past(bc)); endproperty
  a_data_width: assert property (p_data_width) else $error("data width wrong"); // RQ8
  property p_addr_8; s_r.st == M_ADDR && $past(s_r.st) != M_ADDR |-> s_r.bits == 4'h8; endproperty
  a_addr_8: assert property (p_addr_8) else $error("address not 8 bits"); // RQ9
  property p_rx_just; s_r.st == M_DATA && sym_done && !trx && s_r.bits == 4'h1 |=> s_r.rxdata == $past(rx_val) && s_r.rxrdy; endproperty
  a_rx_just: assert property (p_rx_just) else $error("receive data wrong"); // RQ11
  property p_ten_bit; s_r.st == M_ADDR && $past(s_r.st) == M_START && xa |-> s_r.shift[7:3] == TEN_BIT_HDR; endproperty
  a_ten_bit: assert property (p_ten_bit) else $error("ten-bit header wrong"); // RQ14
  property p_count_end; s_r.st == M_LOAD && last_byte && !stp |=> s_r.st == M_HOLD; endproperty
  a_count_end: assert property (p_count_end) else $error("count not honoured"); // RQ15

  c_start_byte: cover property (s_r.st == M_SACK ##[1:1000] s_r.st == M_RSTART);
  c_free_data: cover property (fdf && s_r.st == M_DATA);
  c_hold: cover property (s_r.st == M_HOLD);
  c_slave_sb: cover property (sb_done && sb_val == START_BYTE);
endmodule : i2c_mode_ctrl
`default_nettype wire

// ===== bench/bus_slave_model.sv
// Far-side bus device model: logs data bits and acknowledges each frame
`timescale 1ns/1ps
`default_nettype none
module bus_slave_model (
  // Bus lines
  input wire logic scl,
  input wire logic sda,
  // Frame widths agreed with the master
  input wire logic [3:0] width,
  input wire logic [1:0] hdr,
  output logic sda_pull
);
  logic [63:0] seen = 64'h0;
  logic smp = 1'b1, skip = 1'b0;
  int nb = 0, cnt = 0, frame = 0, starts = 0;
  initial sda_pull = 1'b0;
  always @(negedge sda) begin
    if (scl === 1'b1) begin
      cnt = 0;
      frame = 0;
      skip = 1;
      starts++;
    end
  end
  always @(posedge scl) smp = sda;
  // Bits are committed on the falling clock so a stop never logs one
  always @(negedge scl) begin
    if (skip)
      skip = 0;
    else if (sda_pull) begin
      sda_pull = 0;
      cnt = 0;
      frame++;
    end else begin
      seen = {seen[62:0], smp};
      nb++;
      cnt++;
      if (cnt == ((frame < hdr) ? 8 : width)) sda_pull = 1;
    end
  end
endmodule : bus_slave_model
`default_nettype wire

// ===== bench/i2c_mode_ctrl_test.sv
// Self-checking bench for the two-wire mode control block
`timescale 1ns/1ps
`default_nettype none
module i2c_mode_ctrl_test;
  import i2c_mode_pkg::*;
  logic aclk = 0, aresetn = 0;
  logic awvalid = 0, wvalid = 0, bready = 1, arvalid = 0, rready = 1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, d;
  logic [31:0] wdata = 32'h0, rdata, rv;
  logic [3:0] wstrb = 4'hF, wid = 4'h8;
  logic [1:0] hdr = 2'h1, bresp, rresp, rs;
  logic awready, wready, bvalid, arready, rvalid;
  logic scl_out, scl_oe_n, sda_out, sda_oe_n, sda_pull;
  logic [63:0] exp_bits = 64'h0;
  int exp_n = 0, exp_s = 0, n, i, mismatches = 0, check_count = 0;
  integer seed = 32'h64062A91;
  wire scl_in = scl_oe_n;
  wire sda_in = sda_oe_n & ~sda_pull;
  always #10 aclk = ~aclk;
  ////////////////////////////////////////
  i2c_mode_ctrl #(.QUARTER(2)) i2c_mode_ctrl_i (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .scl_in, .scl_out, .scl_oe_n, .sda_in, .sda_out, .sda_oe_n
  );
  bus_slave_model bus_slave_model_i (.scl(scl_in), .sda(sda_in), .width(wid), .hdr, .sda_pull);
  ////////////////////////////////////////
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [63:0] seen, input logic [63:0] want);
    check_count++;
    if (seen !== want) begin
      mismatches++;
      $display("BAD %0t value seen %h want %h", $time, seen, want);
    end
  endtask : chk
  task automatic tmo;
    mismatches++;
    $display("BAD %0t wait timed out", $time);
    end_sim();
  endtask : tmo
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1;
    wvalid <= 1;
    for (n = 0; n < 500; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
      if (bvalid) break;
    end
    rs = bresp;
    if (n == 500) tmo();
  endtask : wr
  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1;
    for (n = 0; n < 500; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
      if (rvalid) break;
    end
    rv = rdata;
    rs = rresp;
    if (n == 500) tmo();
  endtask : rd
  task automatic push(input logic [7:0] v, input int w);
    for (int k = w - 1; k >= 0; k--) exp_bits = {exp_bits[62:0], v[k]};
    exp_n += w;
  endtask : push
  task automatic xfer(input logic [15:0] mode, input logic [9:0] tgt, input int h, input int w);
    wid <= w[3:0];
    hdr <= h[1:0];
    wr(OFF_MODE, 32'h20);
    wr(OFF_TARGET, {22'h0, tgt});
    wr(OFF_COUNT, 32'h1);
    // A receive reads the released data line as ones
    d = 8'((1 << w) - 1);
    if (mode[TRX_BIT]) d = 8'($random(seed)) & d;
    wr(OFF_TXDATA, {24'h0, d});
    push(d, w);
    wr(OFF_MODE, {16'h0, mode});
    for (i = 0; i < 2000; i++) begin
      rd(OFF_MODE);
      if (rv[MST_BIT] === 1'b0) break;
    end
    if (i == 2000) tmo();
    chk(bus_slave_model_i.seen, exp_bits);
    chk(bus_slave_model_i.nb, exp_n);
    chk(bus_slave_model_i.starts, exp_s);
    if (!mode[TRX_BIT]) begin
      rd(OFF_RXDATA);
      chk(rv[7:0] & d, d);
    end
  endtask : xfer
  ////////////////////////////////////////
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rd(OFF_MODE);
    chk(rv, {16'h0, MODE_RESET});
    wr(OFF_MODE, 32'hFFFFFFD7);
    rd(OFF_MODE);
    chk(rv, 32'h07D7);
    rd(OFF_STATUS);
    chk(rv, 32'h0);
    wr(8'h40, 32'hFFFF);
    chk(rs, RESP_SLVERR);
    rd(8'h40);
    chk({rv, rs}, {32'h0, RESP_SLVERR});
    push(8'h01, 8);
    push({7'h5A, 1'b0}, 8);
    exp_s = 2;
    xfer(16'h2E33, 10'h05A, 1, 3);
    exp_s = 3;
    xfer(16'h2E28, 10'h05A, 0, 8);
    push(8'hF4, 8);
    push(8'hC5, 8);
    exp_s = 4;
    xfer(16'h2F20, 10'h2C5, 2, 8);
    push(8'hB5, 8);
    exp_s = 5;
    xfer(16'h2C25, 10'h05A, 1, 5);
    wr(OFF_MODE, 32'h26A0);
    for (i = 0; i < 2000 && bus_slave_model_i.nb < exp_n + 8; i++) @(posedge aclk);
    if (i == 2000) tmo();
    chk(bus_slave_model_i.seen[7:0], 8'hB4);
    rd(OFF_STATUS);
    chk(rv[ST_BUSY], 1'b1);
    wr(OFF_MODE, 32'h0);
    @(posedge aclk);
    chk({scl_oe_n, sda_oe_n}, 2'b11);
    rd(OFF_STATUS);
    chk(rv, 32'h0);
    end_sim();
  end
endmodule : i2c_mode_ctrl_test
`default_nettype wire
